// file: psrc_pkg.sv
package psrc_pkg;
  // ---------------------------------------------------------------
  // register map (byte offsets from the system control base)
  // ---------------------------------------------------------------
  localparam logic [31:0] sys_ctrl_base = 32'h400fe000;
  localparam logic [11:0] peripheral_soft_reset_one_off = 12'h044;
  localparam logic [11:0] port_soft_reset_off = 12'h048;
  localparam logic [31:0] peripheral_soft_reset_one_rst = 32'h00000000;
  localparam logic [31:0] port_soft_reset_rst = 32'h00000000;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int serial_port_zero_bit = 0;
  localparam int serial_port_one_bit = 1;
  localparam int sync_serial_unit_bit = 4;
  localparam int two_wire_unit_bit = 12;
  localparam int general_counter_zero_bit = 16;
  localparam int general_counter_one_bit = 17;
  localparam int general_counter_two_bit = 18;
  localparam int comparator_zero_bit = 24;
  localparam int port_count = 5;

  // writable bits of each register; all others are reserved
  localparam logic [31:0] peripheral_writable = 32'h01071013;
  localparam logic [31:0] port_writable = 32'h0000001f;

  // ---------------------------------------------------------------
  // carrier for the APB request
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } psrc_req_s;
endpackage

// file: psrc_ctrl.sv
`timescale 1ns/1ps
module psrc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] peripheral_presence_mask,
  input wire logic [31:0] port_presence_mask,
  output logic comparator_zero_reset,
  output logic general_counter_zero_reset,
  output logic general_counter_one_reset,
  output logic general_counter_two_reset,
  output logic two_wire_unit_reset,
  output logic sync_serial_unit_reset,
  output logic serial_port_zero_reset,
  output logic serial_port_one_reset,
  output logic [4:0] parallel_port_reset
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  psrc_pkg::psrc_req_s req;
  logic access;
  logic hit_one;
  logic hit_port;
  logic [31:0] strb_mask;
  // register state and next values; read data is a flop so prdata never glitches
  logic [31:0] one_q;
  logic [31:0] one_d;
  logic [31:0] port_q;
  logic [31:0] port_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign access = psel && penable;
  assign hit_one = req.addr[11:2] == psrc_pkg::peripheral_soft_reset_one_off[11:2];
  assign hit_port = req.addr[11:2] == psrc_pkg::port_soft_reset_off[11:2];
  assign strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !(hit_one || hit_port);

  // ---------------------------------------------------------------
  // register next state
  // ---------------------------------------------------------------
  // presence mask is applied at write time, so a write can neither set nor clear an absent unit's bit
  always_comb begin
    logic [31:0] wm1;
    logic [31:0] wm2;
    wm1 = strb_mask & psrc_pkg::peripheral_writable & peripheral_presence_mask;
    wm2 = strb_mask & psrc_pkg::port_writable & port_presence_mask;
    one_d = one_q;
    port_d = port_q;
    rdata_d = rdata_q;
    if (access && req.write && hit_one) begin
      one_d = (one_q & ~wm1) | (req.wdata & wm1);
    end
    if (access && req.write && hit_port) begin
      port_d = (port_q & ~wm2) | (req.wdata & wm2);
    end
    if (psel && !penable && !req.write) begin
      // read data captured in setup so it is registered for the access cycle
      if (hit_one) begin
        rdata_d = one_q;
      end else if (hit_port) begin
        rdata_d = port_q;
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  // one flop group; asynchronous clear to the reset constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      one_q <= psrc_pkg::peripheral_soft_reset_one_rst;
      port_q <= psrc_pkg::port_soft_reset_rst;
      rdata_q <= 32'h00000000;
    end else begin
      one_q <= one_d;
      port_q <= port_d;
      rdata_q <= rdata_d;
    end
  end

  // read data straight from its flop
  assign prdata = rdata_q;

  // ---------------------------------------------------------------
  // reset request outputs, straight from the flops
  // ---------------------------------------------------------------
  assign serial_port_zero_reset = one_q[psrc_pkg::serial_port_zero_bit];
  assign serial_port_one_reset = one_q[psrc_pkg::serial_port_one_bit];
  assign sync_serial_unit_reset = one_q[psrc_pkg::sync_serial_unit_bit];
  assign two_wire_unit_reset = one_q[psrc_pkg::two_wire_unit_bit];
  assign general_counter_zero_reset = one_q[psrc_pkg::general_counter_zero_bit];
  assign general_counter_one_reset = one_q[psrc_pkg::general_counter_one_bit];
  assign general_counter_two_reset = one_q[psrc_pkg::general_counter_two_bit];
  assign comparator_zero_reset = one_q[psrc_pkg::comparator_zero_bit];
  assign parallel_port_reset = port_q[psrc_pkg::port_count-1:0];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // reserved positions can never hold a one, whatever software writes
  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((one_q & ~psrc_pkg::peripheral_writable) == 32'h0) && (port_q[31:5] == 27'h0))
    else $error("reserved bit set");

  // a full-word write leaves exactly the present, writable bits it carried
  absent_unit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && req.write && hit_one && pstrb == 4'hf) |=>
      one_q == ($past(req.wdata) & psrc_pkg::peripheral_writable & $past(peripheral_presence_mask)))
    else $error("peripheral write not masked");

  // same for the port register
  absent_port_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && req.write && hit_port && pstrb == 4'hf) |=>
      port_q == ($past(req.wdata) & psrc_pkg::port_writable & $past(port_presence_mask)))
    else $error("port write not masked");

  // an absent unit's bit keeps its value through any write, full or partial
  absent_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && req.write && hit_one) |=>
      ((one_q ^ $past(one_q)) & ~$past(peripheral_presence_mask)) == 32'h0)
    else $error("absent unit bit changed");

  // an absent port's bit keeps its value through any write
  absent_port_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && req.write && hit_port) |=>
      ((port_q ^ $past(port_q)) & ~$past(port_presence_mask)) == 32'h0)
    else $error("absent port bit changed");

  // strobes are honoured: a lane left out of a write keeps its old contents
  lane_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && req.write && (hit_one || hit_port)) |=>
      (((one_q ^ $past(one_q)) & ~$past(strb_mask)) == 32'h0) &&
      (((port_q ^ $past(port_q)) & ~$past(strb_mask)) == 32'h0))
    else $error("unstrobed lane changed");

  // read data is taken at setup so it stands for the whole access phase
  read_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_one) |=> prdata == $past(one_q))
    else $error("peripheral read wrong");

  // same for the port register
  read_port_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_port) |=> prdata == $past(port_q))
    else $error("port read wrong");

  // unmapped offsets read zero rather than the last captured word
  unmapped_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && !(hit_one || hit_port)) |=> prdata == 32'h0)
    else $error("unmapped read not zero");

  // an unmapped access flags an error and must not disturb either register
  unmapped_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !(hit_one || hit_port)) |->
      pslverr ##1 ($stable(one_q) && $stable(port_q)))
    else $error("unmapped access misbehaved");

  // error flag only ever rises in the access phase
  err_only_access_a: assert property (@(posedge pclk) disable iff (!presetn)
    !access |-> !pslverr)
    else $error("error flag outside access");

  // serial port bits follow the written data, not merely the flop they read
  uart_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && req.write && hit_one && pstrb == 4'hf) |=>
      (serial_port_one_reset == $past(pwdata[1] & peripheral_presence_mask[1])) &&
      (serial_port_zero_reset == $past(pwdata[0] & peripheral_presence_mask[0])))
    else $error("serial port map wrong");

  // remaining unit bits, same idea; a swapped bit position would show here
  unit_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && req.write && hit_one && pstrb == 4'hf) |=>
      {comparator_zero_reset, general_counter_two_reset, general_counter_one_reset,
        general_counter_zero_reset, two_wire_unit_reset, sync_serial_unit_reset} ==
      $past({pwdata[24], pwdata[18], pwdata[17], pwdata[16], pwdata[12], pwdata[4]} &
        {peripheral_presence_mask[24], peripheral_presence_mask[18],
        peripheral_presence_mask[17], peripheral_presence_mask[16],
        peripheral_presence_mask[12], peripheral_presence_mask[4]}))
    else $error("unit reset map wrong");

  // port bits 4..0 drive ports e..a
  gpio_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && req.write && hit_port && pstrb == 4'hf) |=>
      parallel_port_reset == $past(pwdata[4:0] & port_presence_mask[4:0]))
    else $error("parallel port map wrong");

  // requests only move on a write to their own register
  hold_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(access && pwrite)) |=> $stable(one_q) && $stable(port_q))
    else $error("reset bit changed without write");

  // while reset is low both registers and the read word sit at zero
  reset_clear_a: assert property (@(posedge pclk)
    !presetn |-> (one_q == 32'h0) && (port_q == 32'h0) && (prdata == 32'h0))
    else $error("registers not cleared in reset");

  // and no port, comparator, serial port or two-wire unit is held in reset by a stale request
  reset_outputs_a: assert property (@(posedge pclk)
    !presetn |-> (parallel_port_reset == 5'h00) && !comparator_zero_reset &&
      !serial_port_zero_reset && !serial_port_one_reset && !two_wire_unit_reset)
    else $error("reset request left set in reset");
endmodule

// file: psrc_ctrl_tb.sv
`timescale 1ns/1ps
module psrc_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pmask, qmask, r;
  logic e;
  logic [3:0] pstrb;
  logic [7:0] unit_rst;
  logic [4:0] port_rst;
  int n_fail, tests_run;
  // ----------------------------------------
  // design under test
  // ----------------------------------------
  psrc_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .peripheral_presence_mask(pmask),
    .port_presence_mask(qmask), .comparator_zero_reset(unit_rst[7]),
    .general_counter_two_reset(unit_rst[6]), .general_counter_one_reset(unit_rst[5]),
    .general_counter_zero_reset(unit_rst[4]), .two_wire_unit_reset(unit_rst[3]),
    .sync_serial_unit_reset(unit_rst[2]), .serial_port_one_reset(unit_rst[1]),
    .serial_port_zero_reset(unit_rst[0]), .parallel_port_reset(port_rst));
  // free-running 50 mhz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic stop_test();
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // setup then access; the master never assumes the slave's wait count
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (i = 0; pready !== 1'b1; i++) begin
      if (i > 50) begin
        n_fail++;
        stop_test();
      end
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next setup never lands in the release step
    @(posedge pclk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    tests_run = 0;
    {psel, penable, pwrite, paddr, pwdata, pmask, qmask} = '0;
    pstrb = 4'hf;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h044, 32'h0); chk(r, 32'h00000000);
    chk({31'h0, e}, 32'h00000000);
    apb(1'b0, 12'h048, 32'h0); chk(r, 32'h00000000);
    pmask <= 32'hffffffff;
    qmask <= 32'hffffffff;
    apb(1'b1, 12'h044, 32'hffffffff);
    apb(1'b0, 12'h044, 32'h0); chk(r, 32'h01071013);
    chk({24'h0, unit_rst}, 32'h000000ff);
    apb(1'b1, 12'h044, 32'h00000002); chk({24'h0, unit_rst}, 32'h00000002);
    apb(1'b1, 12'h044, 32'h00000001); chk({24'h0, unit_rst}, 32'h00000001);
    // mask held low on most bits: only counter zero and serial port zero may set
    pmask <= 32'h00010001;
    apb(1'b1, 12'h044, 32'h0); chk({24'h0, unit_rst}, 32'h00000000);
    apb(1'b1, 12'h044, 32'hffffffff);
    apb(1'b0, 12'h044, 32'h0); chk(r, 32'h00010001);
    // only the third byte lane is strobed: the counters alone may change
    pmask <= 32'hffffffff;
    pstrb <= 4'h4;
    apb(1'b1, 12'h044, 32'hffffffff); chk({24'h0, unit_rst}, 32'h00000071);
    pstrb <= 4'hf;
    // unmapped offsets: error flag, zero read, peripheral register untouched
    apb(1'b1, 12'h040, 32'hffffffff); chk({31'h0, e}, 32'h00000001);
    apb(1'b0, 12'h04c, 32'h0); chk(r, 32'h00000000);
    apb(1'b0, 12'h044, 32'h0); chk(r, 32'h00070001);
    qmask <= 32'h0000001b;
    apb(1'b1, 12'h048, 32'hffffffff);
    apb(1'b0, 12'h048, 32'h0); chk(r, 32'h0000001b);
    chk({27'h0, port_rst}, 32'h0000001b);
    apb(1'b1, 12'h048, 32'h00000004); chk({27'h0, port_rst}, 32'h00000000);
    apb(1'b1, 12'h048, 32'hffffffff);
    // reset in mid-run must drop every request it finds set
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({27'h0, port_rst}, 32'h00000000);
    chk({24'h0, unit_rst}, 32'h00000000);
    apb(1'b0, 12'h044, 32'h0); chk(r, 32'h00000000);
    apb(1'b0, 12'h048, 32'h0); chk(r, 32'h00000000);
    stop_test();
  end
endmodule
